// *** rtl/sbc_pkg.sv ***
/*
 * Constants for the serial-bus controller: register map, field positions,
 * reset values, serial clock timing and the transfer item codes.
 * Assumes a 100 MHz system clock.
 */
package sbc_pkg;
	localparam int unsigned CLK_HZ      = 100000000;
	localparam int unsigned SCL_NORM_HZ = 60000;
	localparam int unsigned SCL_TEST_HZ = 4000000;
	// Quarter-bit periods in system clocks
	localparam logic [8:0]  QTR_NORM    = 9'(CLK_HZ / (SCL_NORM_HZ * 4));
	localparam logic [8:0]  QTR_TEST    = 9'(CLK_HZ / (SCL_TEST_HZ * 4));

	localparam logic [7:0]  ADDR_DATA     = 8'hB0;
	localparam logic [7:0]  ADDR_WORD     = 8'hB1;
	localparam logic [7:0]  ADDR_TGT      = 8'hB2;
	localparam logic [7:0]  ADDR_CTL      = 8'hB3;
	localparam logic [7:0]  ADDR_IRQ_ST   = 8'hB8;
	localparam logic [7:0]  ADDR_IRQ_MASK = 8'hB9;

	localparam int CTL_PROT    = 7;
	localparam int CTL_RSVD    = 6;
	localparam int CTL_HBUSY   = 5;
	localparam int CTL_LBUSY   = 4;
	localparam int CTL_PRESENT = 3;
	localparam int CTL_TEST    = 2;
	localparam int CTL_HFAULT  = 1;
	localparam int CTL_LFAULT  = 0;
	localparam int IRQ_DONE    = 0;
	localparam int IRQ_HFAULT  = 1;
	localparam int IRQ_LFAULT  = 2;

	localparam logic [7:0]  REG_RST    = 8'h00;
	localparam logic [2:0]  IRQ_RST    = 3'h0;
	localparam logic [6:0]  EEPROM_TGT = 7'h50;
	localparam logic [7:0]  LOAD_WORD  = 8'h00;

	typedef enum logic [2:0] {
		K_AW = 3'h0, K_AR = 3'h1, K_WORD = 3'h2, K_DATA = 3'h3,
		K_RSTART = 3'h4, K_RX = 3'h5, K_END = 3'h6
	} sbc_kind_e;
endpackage

// *** rtl/sbc_eng_if.sv ***
/*
 * Request and answer signals between the register side and the bit engine.
 * Assumes both ends run on the system clock.
 */
`timescale 1ns/1ns
interface sbc_eng_if;
	logic       req;
	logic       rd;
	logic       prot;
	logic [6:0] tgt;
	logic [7:0] word;
	logic [7:0] wdata;
	logic       busy;
	logic       done;
	logic       fault;
	logic       addr_nack;
	logic [7:0] rdata;
	modport ctl (output req, rd, prot, tgt, word, wdata, input busy, done, fault, addr_nack, rdata);
	modport eng (input req, rd, prot, tgt, word, wdata, output busy, done, fault, addr_nack, rdata);
endinterface

// *** rtl/sbc_clkdiv.sv ***
/*
 * Quarter-bit enable divider for the serial clock.
 * Assumes the system clock and reset of the controller.
 */
`timescale 1ns/1ns
module sbc_clkdiv (
	input  wire logic i_sys_clk, // System clock
	input  wire logic i_nrst,    // Async reset, active low
	input  wire logic i_fast,    // Test rate select
	output logic      o_tick     // Quarter-bit enable pulse
);
	logic [8:0] cnt;
	logic [8:0] lim;

	assign lim = i_fast ? sbc_pkg::QTR_TEST : sbc_pkg::QTR_NORM; // [RULE_06]

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt    <= 9'h000;
			o_tick <= 1'b0;
		end else if (cnt >= lim - 9'h001) begin
			cnt    <= 9'h000;
			o_tick <= 1'b1;
		end else begin
			cnt    <= cnt + 9'h001;
			o_tick <= 1'b0;
		end
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);

	property p_tick_gap;
		o_tick |=> !o_tick [*5];
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("quarter tick too frequent"); // [RULE_06]
	c_fast: cover property (o_tick && i_fast);
endmodule

// *** rtl/sbc_engine.sv ***
/*
 * Two-wire bit engine: start, bytes with acknowledge, repeated start, stop.
 * Assumes synchronised line inputs and a quarter-bit tick from a divider.
 */
`timescale 1ns/1ns
module sbc_engine (
	input  wire logic i_sys_clk, // System clock
	input  wire logic i_nrst,    // Async reset, active low
	input  wire logic i_tick,    // Quarter-bit enable
	input  wire logic i_scl,     // Synchronised clock line
	input  wire logic i_sda,     // Synchronised data line
	output logic      o_scl_oe,  // Pull clock line low
	output logic      o_sda_oe,  // Pull data line low
	sbc_eng_if.eng    e          // Request and answer
);
	typedef enum logic [3:0] {ST_IDLE = 4'h1, ST_START = 4'h2, ST_BIT = 4'h4, ST_STOP = 4'h8} sbc_eng_st_e;

	sbc_eng_st_e        st;
	logic [1:0]         q;
	logic [3:0]         bitn;
	logic [2:0]         step;
	logic [7:0]         sh;
	logic               rd_q;
	logic               prot_q;
	logic               fault_q;
	logic [6:0]         tgt_q;
	logic [7:0]         word_q;
	logic [7:0]         wdata_q;
	logic               adv;
	sbc_pkg::sbc_kind_e kind;
	sbc_pkg::sbc_kind_e next_kind;

	function automatic sbc_pkg::sbc_kind_e kind_at(input logic rd, input logic prot, input logic [2:0] k);
		case ({rd, prot, k})
			5'b00000: kind_at = sbc_pkg::K_AW;
			5'b00001: kind_at = sbc_pkg::K_WORD;
			5'b00010: kind_at = sbc_pkg::K_DATA;
			5'b01000: kind_at = sbc_pkg::K_AW;
			5'b01001: kind_at = sbc_pkg::K_DATA;
			5'b10000: kind_at = sbc_pkg::K_AW;
			5'b10001: kind_at = sbc_pkg::K_WORD;
			5'b10010: kind_at = sbc_pkg::K_RSTART;
			5'b10011: kind_at = sbc_pkg::K_AR;
			5'b10100: kind_at = sbc_pkg::K_RX;
			5'b11000: kind_at = sbc_pkg::K_AR;
			5'b11001: kind_at = sbc_pkg::K_RX;
			default:  kind_at = sbc_pkg::K_END;
		endcase
	endfunction

	function automatic logic [7:0] byte_of(input sbc_pkg::sbc_kind_e k, input logic [6:0] t,
		input logic [7:0] w, input logic [7:0] d);
		case (k)
			sbc_pkg::K_AW:   byte_of = {t, 1'b0};
			sbc_pkg::K_AR:   byte_of = {t, 1'b1};
			sbc_pkg::K_WORD: byte_of = w;
			sbc_pkg::K_DATA: byte_of = d;
			default:         byte_of = 8'h00;
		endcase
	endfunction

	assign kind      = kind_at(rd_q, prot_q, step); // [RULE_01] [RULE_12]
	assign next_kind = kind_at(rd_q, prot_q, step + 3'h1);
	// A released clock line held low by the target stretches the bit
	assign adv       = i_tick && !(q == 2'h2 && !i_scl);
	assign e.busy    = (st != ST_IDLE);
	assign e.fault   = fault_q;

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rd_q    <= 1'b0;
			prot_q  <= 1'b0;
			tgt_q   <= 7'h00;
			word_q  <= 8'h00;
			wdata_q <= 8'h00;
		end else if (st == ST_IDLE && e.req) begin
			rd_q    <= e.rd;
			prot_q  <= e.prot;
			tgt_q   <= e.tgt;
			word_q  <= e.word;
			wdata_q <= e.wdata;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st          <= ST_IDLE;
			q           <= 2'h0;
			bitn        <= 4'h0;
			step        <= 3'h0;
			sh          <= 8'h00;
			fault_q     <= 1'b0;
			e.addr_nack <= 1'b0;
			e.done      <= 1'b0;
			e.rdata     <= 8'h00;
			o_scl_oe    <= 1'b0;
			o_sda_oe    <= 1'b0;
		end else begin
			e.done <= 1'b0;
			case (st)
				ST_IDLE: if (e.req) begin // [RULE_11]
					st          <= ST_START;
					q           <= 2'h0;
					step        <= 3'h0;
					fault_q     <= 1'b0;
					e.addr_nack <= 1'b0;
				end
				ST_START: if (adv) begin
					q <= q + 2'h1;
					case (q)
						2'h0: o_sda_oe <= 1'b0;
						2'h1: o_scl_oe <= 1'b0;
						2'h2: o_sda_oe <= 1'b1;
						default: begin
							o_scl_oe <= 1'b1;
							st       <= ST_BIT;
							bitn     <= 4'h0;
							if (kind == sbc_pkg::K_RSTART) begin
								step <= step + 3'h1;
								sh   <= byte_of(next_kind, tgt_q, word_q, wdata_q);
							end else begin
								sh <= byte_of(kind, tgt_q, word_q, wdata_q);
							end
						end
					endcase
				end
				ST_BIT: if (adv) begin
					q <= q + 2'h1;
					case (q)
						2'h0: o_sda_oe <= (bitn != 4'h8 && kind != sbc_pkg::K_RX) ? !sh[7] : 1'b0;
						2'h1: o_scl_oe <= 1'b0;
						2'h2: begin
							if (bitn == 4'h8) begin
								if (kind != sbc_pkg::K_RX && i_sda) begin
									fault_q <= 1'b1;
								end
							end else if (kind == sbc_pkg::K_RX) begin
								sh <= {sh[6:0], i_sda};
							end
						end
						default: begin
							o_scl_oe <= 1'b1;
							if (bitn != 4'h8) begin
								bitn <= bitn + 4'h1;
								if (kind != sbc_pkg::K_RX) begin
									sh <= {sh[6:0], 1'b0};
								end
							end else begin
								bitn <= 4'h0;
								if (kind == sbc_pkg::K_RX) begin
									e.rdata <= sh; // [RULE_14]
								end
								if (fault_q) begin
									e.addr_nack <= (step == 3'h0);
									st          <= ST_STOP;
								end else if (next_kind == sbc_pkg::K_END) begin
									st <= ST_STOP;
								end else if (next_kind == sbc_pkg::K_RSTART) begin
									st   <= ST_START;
									step <= step + 3'h1;
								end else begin
									step <= step + 3'h1;
									sh   <= byte_of(next_kind, tgt_q, word_q, wdata_q);
								end
							end
						end
					endcase
				end
				ST_STOP: if (adv) begin
					q <= q + 2'h1;
					case (q)
						2'h0: o_sda_oe <= 1'b1;
						2'h1: o_scl_oe <= 1'b0;
						2'h2: o_sda_oe <= 1'b0;
						default: begin
							st     <= ST_IDLE;
							e.done <= 1'b1;
						end
					endcase
				end
				default: st <= ST_IDLE;
			endcase
		end
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);

	property p_no_word;
		(st == ST_BIT && prot_q) |-> kind != sbc_pkg::K_WORD;
	endproperty
	a_no_word: assert property (p_no_word) else $error("word address sent in short mode"); // [RULE_01]
	property p_dir_bit;
		(st == ST_BIT && step == 3'h0 && bitn == 4'h7 && q == 2'h1) |-> o_sda_oe == !(rd_q && prot_q);
	endproperty
	a_dir_bit: assert property (p_dir_bit) else $error("direction bit wrong"); // [RULE_12]
	property p_req_busy;
		(st == ST_IDLE && e.req) |=> e.busy ##1 e.busy;
	endproperty
	a_req_busy: assert property (p_req_busy) else $error("request did not start cycle"); // [RULE_11]
endmodule

// *** rtl/sbc_top.sv ***
/*
 * Serial-bus controller: register file, EEPROM loader after reset and
 * software single-byte cycles over an open-drain two-wire bus.
 * Assumes a plain register port on the system clock and external pull-ups.
 */
// Contract
// [RULE_01] Control bit 7 chooses target plus word address, or target address alone.
// [RULE_02] Control bit 6 is reserved and always reads zero.
// [RULE_03] Bit 5 is one while a software cycle runs, else zero.
// [RULE_04] Bit 4 is one while the EEPROM loader fetches defaults.
// [RULE_05] Bit 3 is set when an EEPROM answers after reset.
// [RULE_06] Bit 2 zero gives about 60 kHz clock, one about 4 MHz.
// [RULE_07] Bit 1 sets on a failed software cycle, stays until cleared.
// [RULE_08] Bit 0 sets on a failed EEPROM download, stays until cleared.
// [RULE_09] All control and status bits reset to zero.
// [RULE_10] Busy and detect bits change by hardware only, never by writes.
// [RULE_11] Writing the target address register starts a serial cycle.
// [RULE_12] Direction bit zero writes one byte, one reads one byte.
// [RULE_13] Software loads data and word address before the target address.
// [RULE_14] Read byte lands in the data register before busy clears.
`timescale 1ns/1ns
module sbc_top (
	input  wire logic       i_sys_clk,   // System clock, 100 MHz
	input  wire logic       i_nrst,      // Async reset, active low
	input  wire logic [7:0] i_addr,      // Register address
	input  wire logic [7:0] i_wdata,     // Register write data
	input  wire logic       i_wr,        // Write strobe
	input  wire logic       i_rd,        // Read strobe
	output logic      [7:0] o_rdata,     // Read data, cycle after strobe
	output logic            o_irq,       // Interrupt level
	input  wire logic       i_scl,       // Clock line level
	output logic            o_scl,       // Clock line drive value
	output logic            o_scl_oe,    // Clock line pulled low
	input  wire logic       i_sda,       // Data line level
	output logic            o_sda,       // Data line drive value
	output logic            o_sda_oe,    // Data line pulled low
	output logic      [7:0] o_load_data  // Byte fetched by the loader
);
	typedef enum logic [2:0] {LD_START = 3'h1, LD_RUN = 3'h2, LD_IDLE = 3'h4} sbc_ld_st_e;

	sbc_eng_if  e ();
	sbc_ld_st_e ld_st;
	logic [1:0] pin_meta;
	logic [1:0] pin_sync;
	logic       tick;
	logic       scl_oe;
	logic       sda_oe;
	logic [7:0] data_reg;
	logic [7:0] word_reg;
	logic [7:0] tgt_reg;
	logic       prot;
	logic       test;
	logic       host_busy;
	logic       load_busy;
	logic       present;
	logic       host_fault;
	logic       load_fault;
	logic       owner_host;
	logic [2:0] irq_st;
	logic [2:0] irq_mask;
	logic [2:0] ev;
	logic [7:0] rd_val;
	logic       wr_data;
	logic       wr_word;
	logic       wr_tgt;
	logic       wr_ctl;
	logic       host_start;
	logic       host_done;
	logic       load_done;

	// Line inputs come from outside the clock domain
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			pin_meta <= 2'h3;
			pin_sync <= 2'h3;
		end else begin
			pin_meta <= {i_scl, i_sda};
			pin_sync <= pin_meta;
		end
	end

	sbc_clkdiv u_div (
		.i_sys_clk (i_sys_clk),
		.i_nrst    (i_nrst),
		.i_fast    (test),
		.o_tick    (tick)
	);

	sbc_engine u_eng (
		.i_sys_clk (i_sys_clk),
		.i_nrst    (i_nrst),
		.i_tick    (tick),
		.i_scl     (pin_sync[1]),
		.i_sda     (pin_sync[0]),
		.o_scl_oe  (scl_oe),
		.o_sda_oe  (sda_oe),
		.e         (e.eng)
	);

	assign o_scl_oe   = scl_oe;
	assign o_sda_oe   = sda_oe;
	assign wr_data    = i_wr && (i_addr == sbc_pkg::ADDR_DATA);
	assign wr_word    = i_wr && (i_addr == sbc_pkg::ADDR_WORD);
	assign wr_tgt     = i_wr && (i_addr == sbc_pkg::ADDR_TGT);
	assign wr_ctl     = i_wr && (i_addr == sbc_pkg::ADDR_CTL);
	// A launch while any cycle or the loader is active is dropped
	assign host_start = wr_tgt && !host_busy && !load_busy && !e.busy && ld_st == LD_IDLE; // [RULE_11]
	assign host_done  = e.done && owner_host;
	assign load_done  = e.done && !owner_host;
	assign ev         = {load_done && e.fault && !e.addr_nack, host_done && e.fault, host_done};

	// Open-drain: the drive value is always low
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_scl <= 1'b0;
			o_sda <= 1'b0;
		end else begin
			o_scl <= 1'b0;
			o_sda <= 1'b0;
		end
	end

	// Engine request, from the loader first and then from software
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			e.req      <= 1'b0;
			e.rd       <= 1'b0;
			e.prot     <= 1'b0;
			e.tgt      <= 7'h00;
			e.word     <= 8'h00;
			e.wdata    <= 8'h00;
			owner_host <= 1'b0;
		end else begin
			e.req <= 1'b0;
			if (ld_st == LD_START) begin
				e.req      <= 1'b1;
				e.rd       <= 1'b1;
				e.prot     <= 1'b0;
				e.tgt      <= sbc_pkg::EEPROM_TGT;
				e.word     <= sbc_pkg::LOAD_WORD;
				owner_host <= 1'b0;
			end else if (host_start) begin
				e.req      <= 1'b1;
				e.rd       <= i_wdata[0]; // [RULE_12]
				e.prot     <= prot; // [RULE_01]
				e.tgt      <= i_wdata[7:1];
				e.word     <= word_reg; // [RULE_13]
				e.wdata    <= data_reg;
				owner_host <= 1'b1;
			end
		end
	end

	// EEPROM loader: probe and fetch once after reset
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ld_st       <= LD_START;
			load_busy   <= 1'b0; // [RULE_09]
			present     <= 1'b0;
			load_fault  <= 1'b0;
			o_load_data <= sbc_pkg::REG_RST;
		end else begin
			case (ld_st)
				LD_START: begin
					ld_st     <= LD_RUN;
					load_busy <= 1'b1; // [RULE_04]
				end
				LD_RUN: if (load_done) begin
					ld_st     <= LD_IDLE;
					load_busy <= 1'b0; // [RULE_04]
				end
				LD_IDLE: ld_st <= LD_IDLE;
				default: ld_st <= LD_IDLE;
			endcase
			if (load_done && !e.addr_nack) begin
				present <= 1'b1; // [RULE_05]
			end
			if (load_done && !e.fault) begin
				o_load_data <= e.rdata;
			end
			if (ev[sbc_pkg::IRQ_LFAULT]) begin
				load_fault <= 1'b1; // [RULE_08]
			end else if (wr_ctl && i_wdata[sbc_pkg::CTL_LFAULT]) begin
				load_fault <= 1'b0;
			end
		end
	end

	// Software cycle status
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			host_busy  <= 1'b0;
			host_fault <= 1'b0;
		end else begin
			if (host_start) begin
				host_busy <= 1'b1; // [RULE_03]
			end else if (host_done) begin
				host_busy <= 1'b0; // [RULE_03]
			end
			if (ev[sbc_pkg::IRQ_HFAULT]) begin
				host_fault <= 1'b1; // [RULE_07]
			end else if (wr_ctl && i_wdata[sbc_pkg::CTL_HFAULT]) begin
				host_fault <= 1'b0;
			end
		end
	end

	// Software registers; only control bits 7 and 2 store written values, bits 1 and 0 clear when written with a one
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			data_reg <= sbc_pkg::REG_RST;
			word_reg <= sbc_pkg::REG_RST;
			tgt_reg  <= sbc_pkg::REG_RST;
			prot     <= 1'b0; // [RULE_09]
			test     <= 1'b0;
		end else begin
			if (host_done && e.rd && !e.fault) begin
				data_reg <= e.rdata; // [RULE_14]
			end else if (wr_data) begin
				data_reg <= i_wdata;
			end
			if (wr_word) begin
				word_reg <= i_wdata;
			end
			if (wr_tgt) begin
				tgt_reg <= i_wdata;
			end
			if (wr_ctl) begin // [RULE_10]
				prot <= i_wdata[sbc_pkg::CTL_PROT];
				test <= i_wdata[sbc_pkg::CTL_TEST]; // [RULE_06]
			end
		end
	end

	// Sticky event bits; a new event wins over a write-one clear
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			irq_st   <= sbc_pkg::IRQ_RST;
			irq_mask <= sbc_pkg::IRQ_RST;
			o_irq    <= 1'b0;
		end else begin
			if (i_wr && i_addr == sbc_pkg::ADDR_IRQ_ST) begin
				irq_st <= (irq_st & ~i_wdata[2:0]) | ev;
			end else begin
				irq_st <= irq_st | ev;
			end
			if (i_wr && i_addr == sbc_pkg::ADDR_IRQ_MASK) begin
				irq_mask <= i_wdata[2:0];
			end
			o_irq <= |(irq_st & irq_mask);
		end
	end

	always_comb begin
		case (i_addr)
			sbc_pkg::ADDR_DATA:     rd_val = data_reg;
			sbc_pkg::ADDR_WORD:     rd_val = word_reg;
			sbc_pkg::ADDR_TGT:      rd_val = tgt_reg;
			sbc_pkg::ADDR_CTL:      rd_val = {prot, 1'b0, host_busy, load_busy, // [RULE_02]
				present, test, host_fault, load_fault};
			sbc_pkg::ADDR_IRQ_ST:   rd_val = {5'h00, irq_st};
			sbc_pkg::ADDR_IRQ_MASK: rd_val = {5'h00, irq_mask};
			default:                rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rdata <= 8'h00;
		end else begin
			o_rdata <= i_rd ? rd_val : 8'h00;
		end
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);

	property p_rsvd_zero;
		(i_rd && i_addr == sbc_pkg::ADDR_CTL) |=> !o_rdata[6] && o_rdata[5] == $past(host_busy);
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read nonzero"); // [RULE_02]
	property p_host_busy;
		host_start |=> host_busy && e.req ##1 e.busy && host_busy;
	endproperty
	a_host_busy: assert property (p_host_busy) else $error("busy not set on launch"); // [RULE_03]
	property p_load_busy;
		ld_st == LD_START |=> load_busy [*3];
	endproperty
	a_load_busy: assert property (p_load_busy) else $error("loader busy missing"); // [RULE_04]
	property p_present;
		(load_done && !e.addr_nack) |=> present;
	endproperty
	a_present: assert property (p_present) else $error("eeprom not flagged present"); // [RULE_05]
	property p_host_fault;
		(host_done && e.fault) |=> host_fault && irq_st[1] && !host_busy;
	endproperty
	a_host_fault: assert property (p_host_fault) else $error("host fault not flagged"); // [RULE_07]
	property p_load_fault;
		(load_done && e.fault && !e.addr_nack) |=> load_fault ##1 load_fault;
	endproperty
	a_load_fault: assert property (p_load_fault) else $error("load fault not flagged"); // [RULE_08]
	property p_hw_only;
		(wr_ctl && !host_busy && ld_st == LD_IDLE) |=> !host_busy && !load_busy;
	endproperty
	a_hw_only: assert property (p_hw_only) else $error("write changed busy bit"); // [RULE_10]
	property p_read_data;
		(host_done && e.rd && !e.fault) |=> data_reg == $past(e.rdata) && !host_busy;
	endproperty
	a_read_data: assert property (p_read_data) else $error("read byte not stored"); // [RULE_14]

	c_host_wr: cover property (host_done && !e.rd && !e.fault);
	c_host_rd: cover property (host_done && e.rd && !e.fault);
	c_irq: cover property (o_irq && present);
endmodule

// *** bench/sbc_eeprom_model.sv ***
/*
 * Behavioural two-wire target standing in for the serial EEPROM.
 * Assumes line levels resolved by the bench with pull-ups; samples them on the system clock.
 */
`timescale 1ns/1ns
module sbc_eeprom_model #(
	parameter logic [6:0] DEV_ADDR = 7'h50 // Address this target answers to
) (
	input  wire logic i_sys_clk, // System clock used to sample the lines
	input  wire logic i_scl,     // Clock line level
	input  wire logic i_sda,     // Data line level
	output logic      o_sda_oe   // Pull data line low
);
	logic [7:0] mem [256];
	logic [7:0] ptr, sh, out;
	logic       scl_q, sda_q, sel, rdm, first, have_ptr;
	int         cnt;

	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
		{o_sda_oe, sel, rdm, first, have_ptr} = '0;
		{scl_q, sda_q} = 2'b11;
		ptr = 8'h00;
		cnt = 0;
	end

	always @(posedge i_sys_clk) begin
		scl_q <= i_scl;
		sda_q <= i_sda;
		if (i_scl && scl_q && sda_q && !i_sda) begin
			cnt <= 0;
			first <= 1'b1;
			o_sda_oe <= 1'b0;
		end else if (i_scl && scl_q && !sda_q && i_sda) begin
			sel <= 1'b0;
			o_sda_oe <= 1'b0;
		end else if (i_scl && !scl_q && cnt < 8) begin
			sh <= {sh[6:0], i_sda};
			cnt <= cnt + 1;
		end else if (!i_scl && scl_q) begin
			if (cnt == 8) begin
				cnt <= 9;
				o_sda_oe <= 1'b0;
				if (first) begin
					first <= 1'b0;
					sel <= (sh[7:1] == DEV_ADDR);
					rdm <= sh[0];
					o_sda_oe <= (sh[7:1] == DEV_ADDR);
					if (!sh[0]) have_ptr <= 1'b0;
				end else if (sel && !rdm) begin
					o_sda_oe <= 1'b1;
					if (!have_ptr) begin
						ptr <= sh;
						have_ptr <= 1'b1;
					end else begin
						mem[ptr] <= sh;
						ptr <= ptr + 8'h01;
					end
				end else if (sel) begin
					// Single-byte read: release the line; the master leaves the acknowledge bit high and stops
					sel <= 1'b0;
					ptr <= ptr + 8'h01;
				end
			end else if (cnt == 9) begin
				cnt <= 0;
				o_sda_oe <= sel && rdm && !mem[ptr][7];
				out <= mem[ptr];
			end else if (sel && rdm && cnt > 0) begin
				o_sda_oe <= !out[7-cnt];
			end
		end
	end
endmodule

// *** bench/sbc_top_tb.sv ***
/*
 * Self-checking bench for the serial-bus controller.
 * Assumes the EEPROM model on the resolved open-drain lines.
 */
`timescale 1ns/1ns
module sbc_top_tb;
	logic       i_sys_clk = 1'b0;
	logic       i_nrst    = 1'b0;
	logic [7:0] i_addr    = 8'h00;
	logic [7:0] i_wdata   = 8'h00;
	logic       i_wr      = 1'b0;
	logic       i_rd      = 1'b0;
	logic [7:0] o_rdata, o_load_data, d;
	logic       o_irq, o_scl, o_scl_oe, o_sda, o_sda_oe, m_sda_oe, scl, sda;
	logic       scl_q     = 1'b1;
	int         fail_count = 0;
	int         compares   = 0;
	int         per        = 0;
	int         ticks      = 0;

	assign scl = !o_scl_oe;
	assign sda = !(o_sda_oe || m_sda_oe);
	always #5 i_sys_clk = !i_sys_clk;

	sbc_top i_sbc_top (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_scl(scl), .o_scl(o_scl),
		.o_scl_oe(o_scl_oe), .i_sda(sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_load_data(o_load_data));
	sbc_eeprom_model i_sbc_eeprom_model (.i_sys_clk(i_sys_clk), .i_scl(scl), .i_sda(sda), .o_sda_oe(m_sda_oe));

	// Clock line period, in system clocks between rising edges
	always @(posedge i_sys_clk) begin
		scl_q <= scl;
		ticks <= (scl && !scl_q) ? 1 : ticks + 1;
		if (scl && !scl_q) per <= ticks;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask

	task automatic wait_idle(input int bit_pos);
		int n;
		n = 0;
		do begin
			rd(sbc_pkg::ADDR_CTL);
			n++;
		end while (d[bit_pos] === 1'b1 && n < 40000);
		if (n >= 40000) begin
			fail_count++;
			end_of_test();
		end
	endtask

	task automatic settle;
		repeat (2) @(posedge i_sys_clk);
		#1;
	endtask

	task automatic t_after_reset;
		logic [7:0] regs [5] = '{sbc_pkg::ADDR_DATA, sbc_pkg::ADDR_WORD, sbc_pkg::ADDR_TGT,
			sbc_pkg::ADDR_IRQ_ST, sbc_pkg::ADDR_IRQ_MASK};
		foreach (regs[i]) begin
			rd(regs[i]);
			chk(d, 8'h00);
		end
		rd(sbc_pkg::ADDR_CTL);
		chk(d, 8'h10);
		wait_idle(sbc_pkg::CTL_LBUSY);
		chk(d, 8'h08);
		chk(o_load_data, 8'hA5);
		chk(16'(per), 16'(4 * sbc_pkg::QTR_NORM));
	endtask

	task automatic t_ctl_bits;
		wr(sbc_pkg::ADDR_CTL, 8'hFF);
		rd(sbc_pkg::ADDR_CTL);
		chk(d, 8'h8C);
		wr(sbc_pkg::ADDR_CTL, 8'h04);
		rd(sbc_pkg::ADDR_CTL);
		chk(d, 8'h0C);
		rd(8'hC5);
		chk(d, 8'h00);
	endtask

	task automatic t_sw_write;
		wr(sbc_pkg::ADDR_IRQ_MASK, 8'h01);
		wr(sbc_pkg::ADDR_DATA, 8'h5A);
		wr(sbc_pkg::ADDR_WORD, 8'h10);
		wr(sbc_pkg::ADDR_TGT, {sbc_pkg::EEPROM_TGT, 1'b0});
		rd(sbc_pkg::ADDR_CTL);
		chk(d, 8'h2C);
		wait_idle(sbc_pkg::CTL_HBUSY);
		chk(d, 8'h0C);
		chk(16'(per), 16'(4 * sbc_pkg::QTR_TEST));
		chk(i_sbc_eeprom_model.mem[16], 8'h5A);
		chk({o_scl, o_sda}, 2'h0);
		chk(o_irq, 1'b1);
		rd(sbc_pkg::ADDR_IRQ_ST);
		chk(d, 8'h01);
		wr(sbc_pkg::ADDR_IRQ_ST, 8'h01);
		settle();
		chk(o_irq, 1'b0);
	endtask

	task automatic t_read(input logic prot, input logic [7:0] exp);
		wr(sbc_pkg::ADDR_CTL, {prot, 7'h04});
		wr(sbc_pkg::ADDR_WORD, 8'h10);
		wr(sbc_pkg::ADDR_TGT, {sbc_pkg::EEPROM_TGT, 1'b1});
		wait_idle(sbc_pkg::CTL_HBUSY);
		chk(o_irq, 1'b1);
		rd(sbc_pkg::ADDR_DATA);
		chk(d, exp);
	endtask

	task automatic t_fault;
		wr(sbc_pkg::ADDR_CTL, 8'h04);
		wr(sbc_pkg::ADDR_IRQ_MASK, 8'h00);
		wr(sbc_pkg::ADDR_IRQ_ST, 8'h07);
		wr(sbc_pkg::ADDR_TGT, {7'h33, 1'b0});
		wait_idle(sbc_pkg::CTL_HBUSY);
		chk(d, 8'h0E);
		chk(o_irq, 1'b0);
		rd(sbc_pkg::ADDR_IRQ_ST);
		chk(d, 8'h03);
		wr(sbc_pkg::ADDR_IRQ_MASK, 8'h02);
		settle();
		chk(o_irq, 1'b1);
		rd(sbc_pkg::ADDR_CTL);
		chk(d, 8'h0E);
		wr(sbc_pkg::ADDR_CTL, 8'h06);
		rd(sbc_pkg::ADDR_CTL);
		chk(d, 8'h0C);
		wr(sbc_pkg::ADDR_IRQ_ST, 8'h07);
		settle();
		chk(o_irq, 1'b0);
	endtask

	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		#(80000 * 10);
		fail_count++;
		end_of_test();
	end

	initial begin
		repeat (4) @(posedge i_sys_clk);
		i_nrst <= 1'b1;
		t_after_reset();
		t_ctl_bits();
		t_sw_write();
		t_read(1'b0, 8'h5A);
		t_read(1'b1, 8'h11 ^ 8'hA5);
		t_fault();
		end_of_test();
	end
endmodule
